/* File: logic/vmk_key_filter.v */
`timescale 1ns/1ns
`default_nettype none
`include "vmk_map.vh"

module vmk_key_filter #(
    parameter DEB_MS = `VMK_DEBOUNCE_MS
) (
    input  wire clk_in,
    input  wire rst_n_in,
    input  wire tick_in,
    input  wire key_n_in,
    output reg  press_out
);

    localparam [31:0] DEB_L = DEB_MS;

    reg        sync1_r;
    reg        sync2_r;
    reg [15:0] stab_r;

    // ****************************************
    // two-stage synchroniser and debounce
    // ****************************************
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_r   <= 1'b1;
            sync2_r   <= 1'b1;
            stab_r    <= 16'h0000;
            press_out <= 1'b0;
        end else begin
            sync1_r <= key_n_in;
            sync2_r <= sync1_r;
            if (~sync2_r == press_out) begin
                stab_r <= 16'h0000;
            end else if (stab_r == DEB_L[15:0]) begin
                press_out <= ~sync2_r;
                stab_r    <= 16'h0000;
            end else if (tick_in) begin
                stab_r <= stab_r + 16'h0001;
            end
        end
    end

endmodule

`default_nettype wire

/* File: logic/vmk_map.vh */
`ifndef VMK_MAP_VH
`define VMK_MAP_VH

// ****************************************
// timing
// ****************************************
`define VMK_CLK_KHZ      25000
`define VMK_DEBOUNCE_MS  20
`define VMK_SETTLE_MS    100
`define VMK_HOLD_MS      3000
`define VMK_IDLE_MS      60000
`define VMK_SLOW_MS      2000
`define VMK_MED_MS       1000
`define VMK_FAST_MS      200
`define VMK_TXRX_MS      100

// ****************************************
// register offsets
// ****************************************
`define VMK_OFS_CFG      8'h00
`define VMK_OFS_STAT     8'h04
`define VMK_OFS_LEARN    8'h08
`define VMK_OFS_CODE     8'h0C
`define VMK_OFS_ADDR     8'h10
`define VMK_OFS_NAME     8'h14

// ****************************************
// fields and reset values
// ****************************************
`define VMK_CFG_VOL_LSB  5
`define VMK_CFG_RST      8'h80
`define VMK_VOL_DEF      3'h4
`define VMK_VOL_MAX      3'h5
`define VMK_MENU_LAST    3'h5
`define VMK_KIND_FLOOR   2'h0
`define VMK_KIND_BGM     2'h1
`define VMK_KIND_SPEC    2'h2
`define VMK_CODE_LIM12   6'h26
`define VMK_BGM_BUILTIN  10'h003
`define VMK_SPEC_LIM     10'h3E8
`define VMK_FLOOR_STRIDE 16'h0260

// ****************************************
// prompt numbers (special voice space)
// ****************************************
`define VMK_PR_UPDATE    10'h001
`define VMK_PR_OPER      10'h00A
`define VMK_PR_CONF      10'h00B
`define VMK_PR_M_VOICE   10'h00C
`define VMK_PR_M_BGM     10'h00F
`define VMK_PR_M_CHIME   10'h015
`define VMK_PR_M_DOOR    10'h018
`define VMK_PR_M_SLIDE   10'h01B
`define VMK_PR_M_VOL     10'h021

`endif

/* File: logic/vmk_top.v */
`timescale 1ns/1ns
`default_nettype none
`include "vmk_map.vh"

module vmk_top #(
    parameter MS_CYC    = `VMK_CLK_KHZ,
    parameter DEB_MS    = `VMK_DEBOUNCE_MS,
    parameter SETTLE_MS = `VMK_SETTLE_MS,
    parameter HOLD_MS   = `VMK_HOLD_MS,
    parameter IDLE_MS   = `VMK_IDLE_MS
) (
    input  wire        REF_CLK_IN,
    input  wire        RST_N_IN,
    input  wire        KEY_MENU_N_IN,
    input  wire        KEY_SET_N_IN,
    input  wire        REPROG_IN,
    input  wire        PLAY_ACTIVE_IN,
    input  wire        CMD_ACTIVE_IN,
    input  wire [7:0]  REG_ADDR_IN,
    input  wire [31:0] REG_WDATA_IN,
    input  wire        REG_WR_IN,
    input  wire        REG_RD_IN,
    output reg  [31:0] REG_RDATA_OUT,
    output reg  [9:0]  PROMPT_OUT,
    output reg         PROMPT_STB_OUT,
    output reg         LEARN_REQ_OUT,
    output reg         PROG_RESET_OUT,
    output reg         LED_RUN_OUT,
    output reg         LED_BUSY_OUT,
    output reg         LED_TXRX_OUT
);

    localparam [6:0] ST_BOOT  = 7'h01;
    localparam [6:0] ST_LWAIT = 7'h02;
    localparam [6:0] ST_STUCK = 7'h04;
    localparam [6:0] ST_LEARN = 7'h08;
    localparam [6:0] ST_OPER  = 7'h10;
    localparam [6:0] ST_CONF  = 7'h20;
    localparam [6:0] ST_FAIL  = 7'h40;

    localparam [31:0] MS_LAST  = MS_CYC - 1;
    localparam [31:0] SETTLE_L = SETTLE_MS;
    localparam [31:0] HOLD_L   = HOLD_MS;
    localparam [31:0] IDLE_L   = IDLE_MS;
    localparam [31:0] SLOW_L   = `VMK_SLOW_MS;
    localparam [31:0] MED_L    = `VMK_MED_MS;
    localparam [31:0] FAST_L   = `VMK_FAST_MS;
    localparam [31:0] TXRX_L   = `VMK_TXRX_MS;

    reg        rst_s1_r;
    reg        rst_n_r;
    reg [2:0]  pin_s1_r;
    reg [2:0]  pin_s2_r;
    reg [15:0] ms_cnt_r;
    reg        ms_tick_r;
    wire [1:0] key_n;
    wire [1:0] key_dn;
    reg  [1:0] key_q_r;

    reg [6:0]  st_r;
    reg [6:0]  st_nxt;
    reg [2:0]  menu_r;
    reg [2:0]  menu_nxt;
    reg [7:0]  cfg_r;
    reg [7:0]  cfg_nxt;
    reg        cin_r;
    reg        cin_nxt;
    reg        pv_r;
    reg        pv_nxt;
    reg        stb_nxt;
    reg [9:0]  prm_nxt;
    reg [15:0] settle_r;
    reg [15:0] hold_r;
    reg [15:0] idle_r;
    reg [15:0] blink_r;
    reg [15:0] txrx_r;
    reg        txrx_ph_r;
    reg [28:0] code_r;
    reg [15:0] period;
    reg [15:0] faddr;
    reg        fvalid;
    reg [2:0]  vol_inc;

    wire       play_s  = pin_s2_r[0];
    wire       cmd_s   = pin_s2_r[1];
    wire       reprog_s = pin_s2_r[2];
    wire       m_rel   = key_q_r[0] & ~key_dn[0];
    wire       s_rel   = key_q_r[1] & ~key_dn[1];
    wire       m_long  = (hold_r == HOLD_L[15:0]);
    wire       any_dn  = |key_dn;
    wire       settled = (settle_r == SETTLE_L[15:0]);
    wire       idle_to = (idle_r == IDLE_L[15:0]);
    wire       wr_cfg  = REG_WR_IN && (REG_ADDR_IN == `VMK_OFS_CFG);
    wire       wr_lrn  = REG_WR_IN && (REG_ADDR_IN == `VMK_OFS_LEARN);
    wire       wr_code = REG_WR_IN && (REG_ADDR_IN == `VMK_OFS_CODE);
    wire [2:0] vol     = cfg_r[7:5];
    wire [5:0] c1      = code_r[5:0];
    wire [5:0] c2      = code_r[11:6];
    wire [3:0] c3      = code_r[15:12];
    wire       lang_e  = code_r[16];
    wire [1:0] kind    = code_r[18:17];
    wire [9:0] num     = code_r[28:19];

    // ****************************************
    // helpers
    // ****************************************
    function [9:0] menu_pr;
        input [2:0] m;
        begin
            case (m)
                3'h0:    menu_pr = `VMK_PR_M_VOICE;
                3'h1:    menu_pr = `VMK_PR_M_BGM;
                3'h2:    menu_pr = `VMK_PR_M_CHIME;
                3'h3:    menu_pr = `VMK_PR_M_DOOR;
                3'h4:    menu_pr = `VMK_PR_M_SLIDE;
                default: menu_pr = `VMK_PR_M_VOL;
            endcase
        end
    endfunction

    // display code to file-name character; space shows as hash
    function [7:0] code_ch;
        input [5:0] c;
        input       third;
        begin
            if (c == 6'h00)
                code_ch = 8'h23;
            else if (third)
                code_ch = (c < 6'h10) ? (8'h40 + {2'h0, c}) : 8'h3F;
            else if (c == 6'h01)
                code_ch = 8'h2D;
            else if (c < 6'h0C)
                code_ch = 8'h2E + {2'h0, c};
            else if (c < `VMK_CODE_LIM12)
                code_ch = 8'h35 + {2'h0, c};
            else
                code_ch = 8'h3F;
        end
    endfunction

    // ****************************************
    // reset release, pin sync, ms tick
    // ****************************************
    always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    always @(posedge REF_CLK_IN or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pin_s1_r  <= 3'h0;
            pin_s2_r  <= 3'h0;
            ms_cnt_r  <= 16'h0000;
            ms_tick_r <= 1'b0;
        end else begin
            pin_s1_r  <= {REPROG_IN, CMD_ACTIVE_IN, PLAY_ACTIVE_IN};
            pin_s2_r  <= pin_s1_r;
            ms_tick_r <= (ms_cnt_r == MS_LAST[15:0]);
            if (ms_cnt_r == MS_LAST[15:0])
                ms_cnt_r <= 16'h0000;
            else
                ms_cnt_r <= ms_cnt_r + 16'h0001;
        end
    end

    assign key_n = {KEY_SET_N_IN, KEY_MENU_N_IN};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_key
            vmk_key_filter #(
                .DEB_MS    (DEB_MS)
            ) u_flt (
                .clk_in    (REF_CLK_IN),
                .rst_n_in  (rst_n_r),
                .tick_in   (ms_tick_r),
                .key_n_in  (key_n[gi]),
                .press_out (key_dn[gi])
            );
        end
    endgenerate

    // ****************************************
    // mode and menu sequencing
    // ****************************************
    always @* begin
        st_nxt   = st_r;
        menu_nxt = menu_r;
        cfg_nxt  = cfg_r;
        cin_nxt  = cin_r;
        pv_nxt   = 1'b0;
        stb_nxt  = 1'b0;
        prm_nxt  = PROMPT_OUT;
        vol_inc  = (vol >= `VMK_VOL_MAX) ? 3'h1 : vol + 3'h1;
        // out-of-range volume writes keep the old level
        if (wr_cfg) begin
            cfg_nxt[4:0] = REG_WDATA_IN[4:0];
            if (REG_WDATA_IN[7:5] != 3'h0 && REG_WDATA_IN[7:5] <= `VMK_VOL_MAX)
                cfg_nxt[7:5] = REG_WDATA_IN[7:5];
        end
        if (pv_r) begin
            stb_nxt = 1'b1;
            prm_nxt = `VMK_PR_OPER;
        end
        case (st_r)
            ST_BOOT: begin
                if (settled) begin
                    if (&key_dn) begin
                        st_nxt = ST_LWAIT;
                    end else if (reprog_s) begin
                        st_nxt = ST_LEARN;
                    end else if (any_dn) begin
                        st_nxt = ST_STUCK;
                    end else begin
                        st_nxt  = ST_OPER;
                        stb_nxt = 1'b1;
                        prm_nxt = `VMK_PR_OPER;
                    end
                end
            end
            ST_LWAIT: begin
                if (!any_dn)
                    st_nxt = ST_LEARN;
            end
            ST_STUCK: begin
                if (!any_dn) begin
                    st_nxt  = ST_OPER;
                    stb_nxt = 1'b1;
                    prm_nxt = `VMK_PR_OPER;
                end
            end
            ST_LEARN: begin
                if (wr_lrn && REG_WDATA_IN[1]) begin
                    st_nxt = ST_FAIL;
                end else if (wr_lrn && REG_WDATA_IN[0]) begin
                    st_nxt  = ST_OPER;
                    stb_nxt = 1'b1;
                    prm_nxt = `VMK_PR_UPDATE;
                    pv_nxt  = 1'b1;
                end
            end
            ST_OPER: begin
                if (key_dn[0] && m_long) begin
                    st_nxt   = ST_CONF;
                    cin_nxt  = 1'b1;
                    menu_nxt = 3'h0;
                    stb_nxt  = 1'b1;
                    prm_nxt  = `VMK_PR_CONF;
                end
            end
            ST_CONF: begin
                if (idle_to) begin
                    st_nxt  = ST_OPER;
                    stb_nxt = 1'b1;
                    prm_nxt = `VMK_PR_OPER;
                end else if (m_rel) begin
                    // the hold that entered this mode must not count on release
                    if (cin_r) begin
                        cin_nxt = 1'b0;
                    end else if (m_long) begin
                        st_nxt  = ST_OPER;
                        stb_nxt = 1'b1;
                        prm_nxt = `VMK_PR_OPER;
                    end else begin
                        menu_nxt = (menu_r == `VMK_MENU_LAST) ? 3'h0 : menu_r + 3'h1;
                        stb_nxt  = 1'b1;
                        prm_nxt  = menu_pr(menu_nxt);
                    end
                end else if (s_rel) begin
                    stb_nxt = 1'b1;
                    if (menu_r == `VMK_MENU_LAST) begin
                        cfg_nxt[7:5] = vol_inc;
                        prm_nxt = `VMK_PR_M_VOL + {7'h00, vol_inc};
                    end else begin
                        cfg_nxt[menu_r] = ~cfg_r[menu_r];
                        prm_nxt = menu_pr(menu_r) + 10'h001 + {9'h000, ~cfg_r[menu_r]};
                    end
                end
            end
            ST_FAIL: begin
                st_nxt = ST_FAIL;
            end
            default: begin
                st_nxt = ST_BOOT;
            end
        endcase
    end

    // ****************************************
    // state, timers and lamps
    // ****************************************
    always @* begin
        case (st_r)
            ST_OPER:  period = SLOW_L[15:0];
            ST_CONF:  period = MED_L[15:0];
            default:  period = FAST_L[15:0];
        endcase
    end

    always @(posedge REF_CLK_IN or negedge rst_n_r) begin
        if (!rst_n_r) begin
            st_r           <= ST_BOOT;
            menu_r         <= 3'h0;
            cfg_r          <= `VMK_CFG_RST;
            cin_r          <= 1'b0;
            pv_r           <= 1'b0;
            key_q_r        <= 2'h0;
            settle_r       <= 16'h0000;
            hold_r         <= 16'h0000;
            idle_r         <= 16'h0000;
            blink_r        <= 16'h0000;
            txrx_r         <= 16'h0000;
            txrx_ph_r      <= 1'b0;
            PROMPT_OUT     <= 10'h000;
            PROMPT_STB_OUT <= 1'b0;
            LEARN_REQ_OUT  <= 1'b0;
            PROG_RESET_OUT <= 1'b0;
            LED_RUN_OUT    <= 1'b0;
            LED_BUSY_OUT   <= 1'b0;
            LED_TXRX_OUT   <= 1'b0;
        end else begin
            st_r           <= st_nxt;
            menu_r         <= menu_nxt;
            cfg_r          <= cfg_nxt;
            cin_r          <= cin_nxt;
            pv_r           <= pv_nxt;
            key_q_r        <= key_dn;
            PROMPT_OUT     <= prm_nxt;
            PROMPT_STB_OUT <= stb_nxt;
            LEARN_REQ_OUT  <= (st_nxt == ST_LEARN);
            PROG_RESET_OUT <= (st_nxt == ST_FAIL);
            if (st_r == ST_BOOT && ms_tick_r && !settled)
                settle_r <= settle_r + 16'h0001;
            // counter saturates so a long hold still reads as long at release
            if (!key_dn[0])
                hold_r <= 16'h0000;
            else if (ms_tick_r && !m_long)
                hold_r <= hold_r + 16'h0001;
            if (st_r != ST_CONF || any_dn)
                idle_r <= 16'h0000;
            else if (ms_tick_r && !idle_to)
                idle_r <= idle_r + 16'h0001;
            if (ms_tick_r)
                blink_r <= (blink_r >= period - 16'h0001) ? 16'h0000 : blink_r + 16'h0001;
            if (st_r == ST_FAIL)
                LED_RUN_OUT <= 1'b1;
            else if (st_r == ST_BOOT)
                LED_RUN_OUT <= 1'b0;
            else
                LED_RUN_OUT <= (blink_r < {1'b0, period[15:1]});
            LED_BUSY_OUT <= play_s;
            if (!cmd_s) begin
                txrx_r    <= 16'h0000;
                txrx_ph_r <= 1'b0;
            end else if (ms_tick_r) begin
                if (txrx_r == TXRX_L[15:0] - 16'h0001) begin
                    txrx_r    <= 16'h0000;
                    txrx_ph_r <= ~txrx_ph_r;
                end else begin
                    txrx_r <= txrx_r + 16'h0001;
                end
            end
            LED_TXRX_OUT <= cmd_s & txrx_ph_r;
        end
    end

    // ****************************************
    // file address from display code
    // ****************************************
    always @* begin
        faddr  = 16'h0000;
        fvalid = 1'b0;
        case (kind)
            `VMK_KIND_FLOOR: begin
                faddr  = ({10'h000, c1} * `VMK_FLOOR_STRIDE) + {6'h00, c2, 4'h0}
                         + {12'h000, c3};
                fvalid = (c1 < `VMK_CODE_LIM12) && (c2 < `VMK_CODE_LIM12);
            end
            `VMK_KIND_BGM: begin
                faddr  = {6'h00, num};
                fvalid = (num < `VMK_BGM_BUILTIN);
            end
            `VMK_KIND_SPEC: begin
                faddr  = {6'h00, num};
                fvalid = (num < `VMK_SPEC_LIM);
            end
            default: begin
                faddr  = 16'h0000;
                fvalid = 1'b0;
            end
        endcase
    end

    // ****************************************
    // register port
    // ****************************************
    always @(posedge REF_CLK_IN or negedge rst_n_r) begin
        if (!rst_n_r) begin
            code_r        <= 29'h0000_0000;
            REG_RDATA_OUT <= 32'h0000_0000;
        end else begin
            if (wr_code)
                code_r <= REG_WDATA_IN[28:0];
            REG_RDATA_OUT <= 32'h0000_0000;
            if (REG_RD_IN) begin
                case (REG_ADDR_IN)
                    `VMK_OFS_CFG:   REG_RDATA_OUT <= {24'h00_0000, cfg_r};
                    `VMK_OFS_STAT:  REG_RDATA_OUT <= {20'h0_0000, play_s, menu_r, 1'b0, st_r};
                    `VMK_OFS_LEARN: REG_RDATA_OUT <= {31'h0000_0000, LEARN_REQ_OUT};
                    `VMK_OFS_CODE:  REG_RDATA_OUT <= {3'h0, code_r};
                    `VMK_OFS_ADDR:  REG_RDATA_OUT <= {15'h0000, fvalid, faddr};
                    `VMK_OFS_NAME:  REG_RDATA_OUT <= {(lang_e ? 8'h45 : 8'h43),
                                                      code_ch(c1, 1'b0), code_ch(c2, 1'b0),
                                                      code_ch({2'h0, c3}, 1'b1)};
                    default:        REG_RDATA_OUT <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "vmk_map.vh"
// ****
// bench
// ****
module tb_top;
    logic        clk = 1'b0, rst_n = 1'b0, reprog = 1'b0, play = 1'b0, cmd = 1'b0;
    logic        wr = 1'b0, rd = 1'b0, stb, learn, pfail, run, busy, txrx, menu_n, set_n;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [9:0]  prompt;
    int          n_mismatch = 0, checks_done = 0, waited, cyc = 0, n;
    logic [9:0]  mp [6] = '{`VMK_PR_M_VOICE, `VMK_PR_M_BGM, `VMK_PR_M_CHIME, `VMK_PR_M_DOOR,
                           `VMK_PR_M_SLIDE, `VMK_PR_M_VOL};
    logic [31:0] cd [7] = '{32'h0000_f965, 32'h0000_0026, 32'h0012_0000, 32'h001a_0000,
                           32'h1f3c_0000, 32'h1f44_0000, 32'h0006_0000};
    logic [31:0] ad [7] = '{32'h0001_5a3f, 0, 32'h0001_0000, 0, 32'h0001_0000, 0, 0};
    always #20 clk = ~clk;
    vmk_top #(.MS_CYC(4), .DEB_MS(2), .SETTLE_MS(3), .HOLD_MS(10), .IDLE_MS(3000)) u_vmk_top (
        .REF_CLK_IN(clk), .RST_N_IN(rst_n), .KEY_MENU_N_IN(menu_n), .KEY_SET_N_IN(set_n),
        .REPROG_IN(reprog), .PLAY_ACTIVE_IN(play), .CMD_ACTIVE_IN(cmd), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
        .PROMPT_OUT(prompt), .PROMPT_STB_OUT(stb), .LEARN_REQ_OUT(learn),
        .PROG_RESET_OUT(pfail), .LED_RUN_OUT(run), .LED_BUSY_OUT(busy), .LED_TXRX_OUT(txrx));
    vmk_operator u_op (.clk_in(clk), .led_run_in(run), .menu_n_out(menu_n), .set_n_out(set_n));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd32(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata & m, exp);
    endtask
    task automatic wait_stb(input logic [9:0] exp, input int lim);
        waited = 0;
        @(negedge clk);
        while (stb !== 1'b1 && waited < lim) begin
            @(negedge clk);
            waited++;
        end
        chk({21'h0, stb, prompt}, {21'h0, 1'b1, exp});
    endtask
    // lit half of the run lamp period, in cycles
    task automatic lamp(input int exp);
        for (n = 0; n < 9000 && run !== 1'b0; n++) @(negedge clk);
        for (n = 0; n < 9000 && run !== 1'b1; n++) @(negedge clk);
        for (n = 0; n < 9000 && run === 1'b1; n++) @(negedge clk);
        chk(n, exp);
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        do_reset();
        wait_stb(`VMK_PR_OPER, 40);
        rd32(`VMK_OFS_STAT, 32'h0000_0010, 32'h0000_007f);
        rd32(`VMK_OFS_CFG, 32'h0000_0080, 32'hffff_ffff);
        rd32(8'h40, 32'h0000_0000, 32'hffff_ffff);
        lamp(4000);
        for (int i = 0; i < 7; i++) begin
            wr32(`VMK_OFS_CODE, cd[i]);
            rd32(`VMK_OFS_ADDR, ad[i], i == 0 ? 32'h0001_ffff : 32'h0001_0000);
        end
        wr32(`VMK_OFS_CODE, 32'h0001_1040);
        rd32(`VMK_OFS_NAME, 32'h4523_2d41, 32'hffff_ffff);
        wr32(`VMK_OFS_CODE, 32'h0000_f94c);
        rd32(`VMK_OFS_NAME, 32'h4341_5a4f, 32'hffff_ffff);
        $display("test boot done");
        u_op.down(1'b1, 1'b0);
        wait_stb(`VMK_PR_CONF, 100);
        u_op.up();
        lamp(2000);
        for (int i = 0; i < 6; i++) begin
            u_op.tap(1'b0, 1'b1);
            wait_stb(i == 5 ? 10'h026 : mp[i] + 10'h002, 40);
            if (i == 5) begin
                u_op.tap(1'b0, 1'b1);
                wait_stb(10'h022, 40);
            end
            u_op.tap(1'b1, 1'b0);
            wait_stb(mp[(i + 1) % 6], 40);
        end
        rd32(`VMK_OFS_CFG, 32'h0000_003f, 32'hffff_ffff);
        wr32(`VMK_OFS_CFG, 32'h0000_00c1);
        rd32(`VMK_OFS_CFG, 32'h0000_0021, 32'hffff_ffff);
        u_op.down(1'b1, 1'b0);
        repeat (60) @(posedge clk);
        u_op.up();
        wait_stb(`VMK_PR_OPER, 40);
        u_op.down(1'b1, 1'b0);
        wait_stb(`VMK_PR_CONF, 100);
        u_op.up();
        wait_stb(`VMK_PR_OPER, 12100);
        chk(waited >= 11800, 1);
        $display("test menu done");
        @(posedge clk) play <= 1'b1;
        // busy reaches the status word only after the two-flop synchroniser
        repeat (3) @(posedge clk);
        rd32(`VMK_OFS_STAT, 32'h0000_0800, 32'h0000_0800);
        chk(busy, 1'b1);
        @(posedge clk) play <= 1'b0;
        @(posedge clk) cmd <= 1'b1;
        n = 0;
        repeat (1600) @(negedge clk) n += txrx;
        chk(n >= 700 && n <= 900, 1);
        @(posedge clk) cmd <= 1'b0;
        $display("test lamps done");
        fork
            do_reset();
            u_op.boot_keys(1'b1, 1'b1);
        join
        repeat (40) @(posedge clk);
        chk(learn, 1'b1);
        lamp(400);
        wr32(`VMK_OFS_LEARN, 32'h0000_0001);
        wait_stb(`VMK_PR_UPDATE, 2);
        wait_stb(`VMK_PR_OPER, 2);
        @(posedge clk) reprog <= 1'b1;
        do_reset();
        repeat (40) @(posedge clk);
        chk(learn, 1'b1);
        wr32(`VMK_OFS_LEARN, 32'h0000_0002);
        repeat (3) @(posedge clk);
        chk({pfail, run}, 2'b11);
        rd32(`VMK_OFS_STAT, 32'h0000_0040, 32'h0000_007f);
        @(posedge clk) reprog <= 1'b0;
        $display("test learn done");
        u_op.down(1'b0, 1'b1);
        do_reset();
        // the first lit phase after boot is cut short, so start inside it
        repeat (40) @(posedge clk);
        lamp(400);
        rd32(`VMK_OFS_STAT, 32'h0000_0004, 32'h0000_007f);
        u_op.up();
        repeat (40) @(posedge clk);
        rd32(`VMK_OFS_STAT, 32'h0000_0010, 32'h0000_007f);
        $display("test stuck done");
        end_of_test();
    end
endmodule
`default_nettype wire

/* File: verification/vmk_operator.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// operator at the two keys
// ****
module vmk_operator (
    input  wire logic clk_in,
    input  wire logic led_run_in,
    output var  logic menu_n_out = 1'b1,
    output var  logic set_n_out = 1'b1
);
    task automatic down(input logic m, input logic s);
        @(posedge clk_in);
        menu_n_out <= !m;
        set_n_out <= !s;
    endtask
    // released keys read high, the pull-up level
    task automatic up();
        @(posedge clk_in);
        menu_n_out <= 1'b1;
        set_n_out <= 1'b1;
    endtask
    task automatic tap(input logic m, input logic s);
        down(m, s);
        repeat (20) @(posedge clk_in);
        up();
    endtask
    // keys held through power-up, let go once the run lamp lights
    task automatic boot_keys(input logic m, input logic s);
        down(m, s);
        for (int n = 0; n < 4000 && led_run_in !== 1'b1; n++) @(posedge clk_in);
        up();
    endtask
endmodule
`default_nettype wire

/* File: verification/vmk_top_props.sv */
`timescale 1ns/1ns
`default_nettype none
`include "vmk_map.vh"
// ****
// prompt and lamp checks
// ****
module vmk_props (
    input wire logic       REF_CLK_IN,
    input wire logic       RST_N_IN,
    input wire logic       PLAY_ACTIVE_IN,
    input wire logic       CMD_ACTIVE_IN,
    input wire logic [9:0] PROMPT_OUT,
    input wire logic       PROMPT_STB_OUT,
    input wire logic       LEARN_REQ_OUT,
    input wire logic       PROG_RESET_OUT,
    input wire logic       LED_RUN_OUT,
    input wire logic       LED_BUSY_OUT,
    input wire logic       LED_TXRX_OUT
);
    logic [3:0] up_r;
    // synchronisers hold stale values for a few edges after reset
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) up_r <= 4'h0;
        else if (up_r != 4'hf) up_r <= up_r + 4'h1;
    end
    default clocking dc @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);
    AST_STB_ONE: assert property (PROMPT_STB_OUT && PROMPT_OUT != `VMK_PR_UPDATE |=> !PROMPT_STB_OUT)
        else $error("prompt strobe too long");
    AST_UPD_PAIR: assert property (PROMPT_STB_OUT && PROMPT_OUT == `VMK_PR_UPDATE |=> PROMPT_STB_OUT && PROMPT_OUT == `VMK_PR_OPER)
        else $error("update prompt not followed by operation prompt");
    AST_PR_RANGE: assert property (PROMPT_STB_OUT |-> PROMPT_OUT == `VMK_PR_UPDATE || (PROMPT_OUT >= `VMK_PR_OPER && PROMPT_OUT <= 10'h026))
        else $error("prompt number out of range");
    AST_FAIL_LAMP: assert property (PROG_RESET_OUT ##1 PROG_RESET_OUT |-> LED_RUN_OUT)
        else $error("run lamp not steady in failure");
    AST_FAIL_MUTE: assert property (PROG_RESET_OUT ##1 PROG_RESET_OUT |-> !PROMPT_STB_OUT && !LEARN_REQ_OUT)
        else $error("failure not silent");
    AST_FAIL_SRC: assert property ($rose(PROG_RESET_OUT) |-> $past(LEARN_REQ_OUT))
        else $error("failure without learning");
    AST_BUSY_ON: assert property (up_r == 4'hf ##0 PLAY_ACTIVE_IN [*4] |-> LED_BUSY_OUT)
        else $error("busy lamp off while playing");
    AST_BUSY_OFF: assert property (up_r == 4'hf ##0 !PLAY_ACTIVE_IN [*4] |-> !LED_BUSY_OUT)
        else $error("busy lamp on while silent");
    AST_TXRX_OFF: assert property (up_r == 4'hf ##0 !CMD_ACTIVE_IN [*4] |-> !LED_TXRX_OUT)
        else $error("link lamp on without command");
endmodule
bind vmk_top vmk_props u_props (.REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN),
    .PLAY_ACTIVE_IN(PLAY_ACTIVE_IN), .CMD_ACTIVE_IN(CMD_ACTIVE_IN), .PROMPT_OUT(PROMPT_OUT),
    .PROMPT_STB_OUT(PROMPT_STB_OUT), .LEARN_REQ_OUT(LEARN_REQ_OUT),
    .PROG_RESET_OUT(PROG_RESET_OUT), .LED_RUN_OUT(LED_RUN_OUT), .LED_BUSY_OUT(LED_BUSY_OUT),
    .LED_TXRX_OUT(LED_TXRX_OUT));
`default_nettype wire
